/* File: rtl/rxb_manager.sv */
// Purpose: Receive MAC DMA buffer manager with call registers and queue
// Assumes: AXI4-Lite slave, MAC reports frames as single-cycle pulses
// Notes: Calls start by writing a call code; result appears in R0
//
// Summary of operation
// - Nonzero R6 or R7 for release, or nonzero R7 for source control or enable, returns the invalid-call code in R0.
// - Release returns 00x success, 010 invalid, 011 no buffer at R4.
// - Release returns 100 when buffer part at R5 was already released.
// - Software reads the buffer information queue of up to 32 entries.
// - Frames from disabled sources are discarded by full buffer release.
// - Each judged frame raises a normal or an error event.
// - Each frame source, as named by its bits 2..0, can be disabled separately by the control call.
// - Entry bits 15..0 equal start address bits 26..11.
// - Start address is 00001b, one, list index, then zeros.
// - Disable with R4 bit 0 clear waits while reception runs.
// - Disable with R4 bit 0 set forcibly resets an enabled DMA.
// - Disable call does nothing when the DMA is already off.
// - Error status gives four bits, bit 1 zero, bit 2 size overflow.
// - Done interrupt stays high while the queue holds entries.
// - Entry bit 28 is valid flag, bits 27..16 the word count.
`timescale 1ns/10ps
module rxb_manager #(
    parameter int DEPTH = rxb_pkg::QUEUE_DEPTH,
    parameter int NBUF = 128
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [rxb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rxb_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mac_frame_start,
    input wire logic mac_frame_end,
    input wire logic mac_frame_ok,
    input wire logic [rxb_pkg::SRC_W-1:0] mac_frame_src,
    input wire logic [rxb_pkg::WORD_W:0] mac_frame_words,
    output logic rx_dma_active,
    output logic frame_normal_evt,
    output logic frame_error_evt,
    output logic rx_dma_done_irq,
    output logic irq
);
    localparam int QAW = $clog2(DEPTH);
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;

    typedef struct packed {
        logic awready, wready, have_aw, have_w, bvalid, arready, rvalid;
        logic rd_pend, rd_queue, dma_en, in_frame, dis_pend;
        logic evt_ok, evt_err, done_irq, irq;
        logic [7:0] awaddr;
        logic [1:0] bresp, rresp;
        logic [31:0] wdata, rdata, r0, r4, r5, r6, r7;
        logic [rxb_pkg::SRC_W-1:0] src_dis;
        logic [NBUF-1:0] buf_used;
        logic [QAW-1:0] wptr, rptr;
        logic [QAW:0] count;
        logic [3:0] err;
        logic [rxb_pkg::IRQ_W-1:0] irq_st, irq_mask;
        logic [6:0] cur_buf;
    } rxb_state_s;

    rxb_state_s st_r, st_nxt;
    logic rst_s1_r, rst_n_r;
    logic [31:0] q_rdata, q_wdata;
    logic q_we;

    // Forms the start address of a buffer from its list index
    function automatic logic [31:0] buf_start(input logic [6:0] idx);
        buf_start = {rxb_pkg::ADDR_TOP, 1'b1, idx, 19'h00000};
    endfunction : buf_start

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    rxb_queue_mem #(.WIDTH(32), .DEPTH(DEPTH)) u_mem (
        .ref_clk(ref_clk),
        .clk_en(clk_en),
        .wr_en(q_we),
        .wr_addr(st_r.wptr),
        .wr_data(q_wdata),
        .rd_addr(st_r.rptr),
        .rd_data(q_rdata)
    );

    always_comb begin
        logic [31:0] addr4, addr5, sa;
        logic [6:0] idx4, idx5, nb;
        logic wr_go, src_off, q_pop;
        logic [rxb_pkg::IRQ_W-1:0] ev;
        st_nxt = st_r;
        addr4 = st_r.r4;
        addr5 = st_r.r5;
        idx4 = addr4[25:19];
        idx5 = addr5[25:19];
        ev = '0;
        q_pop = 1'b0;
        q_we = 1'b0;
        nb = st_r.cur_buf + 7'h01;
        src_off = st_r.src_dis[mac_frame_src[2:0]];
        wr_go = st_r.have_aw && st_r.have_w && !st_r.bvalid;
        sa = buf_start(st_r.cur_buf);
        q_wdata = '0;
        q_wdata[rxb_pkg::ENT_VALID] = 1'b1;
        q_wdata[27:16] = mac_frame_words[rxb_pkg::WORD_W-1:0];
        q_wdata[15:0] = sa[rxb_pkg::ENT_ADDR_HI:rxb_pkg::ENT_ADDR_LO];
        st_nxt.evt_ok = 1'b0;
        st_nxt.evt_err = 1'b0;

        // Write channel
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.awaddr = s_axi_awaddr;
            st_nxt.have_aw = 1'b1;
            st_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.wdata = s_axi_wdata;
            st_nxt.have_w = 1'b1;
            st_nxt.wready = 1'b0;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
            st_nxt.awready = 1'b1;
            st_nxt.wready = 1'b1;
        end
        if (wr_go) begin
            st_nxt.have_aw = 1'b0;
            st_nxt.have_w = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OK;
            unique case (st_r.awaddr)
                rxb_pkg::OFS_R4: st_nxt.r4 = st_r.wdata;
                rxb_pkg::OFS_R5: st_nxt.r5 = st_r.wdata;
                rxb_pkg::OFS_R6: st_nxt.r6 = st_r.wdata;
                rxb_pkg::OFS_R7: st_nxt.r7 = st_r.wdata;
                rxb_pkg::OFS_IRQ_MASK:
                    st_nxt.irq_mask = st_r.wdata[rxb_pkg::IRQ_W-1:0];
                rxb_pkg::OFS_CALL: begin
                    unique case (st_r.wdata[2:0])
                        rxb_pkg::CALL_RELEASE: begin
                            if (st_r.r6 != '0 || st_r.r7 != '0) begin
                                st_nxt.r0 = {29'h0, rxb_pkg::RES_INVALID};
                            end else if (addr4[31:27] != rxb_pkg::ADDR_TOP
                                    || !addr4[26] || addr4[18:0] != '0) begin
                                st_nxt.r0 = {29'h0, rxb_pkg::RES_NO_BUF};
                            end else if (!st_r.buf_used[idx5]
                                    || addr5[31:19] != addr4[31:19]) begin
                                st_nxt.r0 = {29'h0, rxb_pkg::RES_FREED};
                            end else begin
                                st_nxt.buf_used[idx4] = 1'b0;
                                st_nxt.r0 = {29'h0, rxb_pkg::RES_OK};
                            end
                        end
                        rxb_pkg::CALL_SRC_CTRL: begin
                            if (st_r.r7 != '0) begin
                                st_nxt.r0 = {29'h0, rxb_pkg::RES_INVALID};
                            end else begin
                                st_nxt.src_dis = st_r.r4[rxb_pkg::SRC_W-1:0];
                                st_nxt.r0 = '0;
                            end
                        end
                        rxb_pkg::CALL_ENABLE: begin
                            if (st_r.r7 != '0) begin
                                st_nxt.r0 = {29'h0, rxb_pkg::RES_INVALID};
                            end else begin
                                st_nxt.dma_en = 1'b1;
                                st_nxt.r0 = '0;
                            end
                        end
                        rxb_pkg::CALL_DISABLE: begin
                            st_nxt.r0 = '0;
                            if (!st_r.dma_en) begin
                                st_nxt.dis_pend = 1'b0;
                            end else if (st_r.r4[0]) begin
                                st_nxt.dma_en = 1'b0;
                                st_nxt.in_frame = 1'b0;
                                st_nxt.dis_pend = 1'b0;
                            end else if (st_r.in_frame) begin
                                st_nxt.dis_pend = 1'b1;
                            end else begin
                                st_nxt.dma_en = 1'b0;
                            end
                        end
                        rxb_pkg::CALL_ERRSTAT: begin
                            st_nxt.r0 = {28'h0, st_r.err[3:2], 1'b0,
                                         st_r.err[0]};
                            st_nxt.err = '0;
                        end
                        default: st_nxt.r0 = {29'h0, rxb_pkg::RES_INVALID};
                    endcase
                end
                rxb_pkg::OFS_R0, rxb_pkg::OFS_QUEUE, rxb_pkg::OFS_STAT,
                rxb_pkg::OFS_IRQ_ST, rxb_pkg::OFS_SRC_DIS:
                    st_nxt.bresp = RESP_OK;
                default: st_nxt.bresp = RESP_ERR;
            endcase
        end

        // Frame path from the MAC
        if (mac_frame_start && st_r.dma_en && !st_r.in_frame) begin
            st_nxt.in_frame = 1'b1;
        end
        if (mac_frame_end && st_r.in_frame) begin
            st_nxt.in_frame = 1'b0;
            st_nxt.dma_en &= !st_r.dis_pend;
            st_nxt.dis_pend &= !st_r.dis_pend;
            st_nxt.err[rxb_pkg::ERR_SIZE] |= mac_frame_words >
                (rxb_pkg::WORD_W+1)'(rxb_pkg::MAX_WORDS);
            if (mac_frame_ok) begin
                st_nxt.evt_ok = 1'b1;
                ev[rxb_pkg::IRQ_NORMAL] = 1'b1;
            end else begin
                st_nxt.evt_err = 1'b1;
                ev[rxb_pkg::IRQ_ERROR] = 1'b1;
                st_nxt.err[rxb_pkg::ERR_FRAME] = 1'b1;
            end
            if (src_off || !mac_frame_ok) begin
                st_nxt.err[rxb_pkg::ERR_DISCARD] |= src_off;
            end else if (st_r.count != (QAW+1)'(DEPTH)) begin
                q_we = 1'b1;
                st_nxt.buf_used[st_r.cur_buf] = 1'b1;
                st_nxt.cur_buf = nb;
                st_nxt.wptr = st_r.wptr + 1'b1;
                ev[rxb_pkg::IRQ_QUEUE] = 1'b1;
            end
        end

        // Read channel
        if (s_axi_rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
            st_nxt.arready = 1'b1;
        end
        st_nxt.rd_pend = 1'b0;
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.arready = 1'b0;
            st_nxt.rd_pend = 1'b1;
            st_nxt.rd_queue = s_axi_araddr == rxb_pkg::OFS_QUEUE;
            st_nxt.rresp = RESP_OK;
            unique case (s_axi_araddr)
                rxb_pkg::OFS_R0: st_nxt.rdata = st_r.r0;
                rxb_pkg::OFS_R4: st_nxt.rdata = st_r.r4;
                rxb_pkg::OFS_R5: st_nxt.rdata = st_r.r5;
                rxb_pkg::OFS_R6: st_nxt.rdata = st_r.r6;
                rxb_pkg::OFS_R7: st_nxt.rdata = st_r.r7;
                rxb_pkg::OFS_QUEUE: st_nxt.rdata = '0;
                rxb_pkg::OFS_STAT:
                    st_nxt.rdata = 32'({st_r.count, st_r.dma_en});
                rxb_pkg::OFS_IRQ_ST: begin
                    st_nxt.rdata = {29'h0, st_r.irq_st};
                    st_nxt.irq_st = '0;
                end
                rxb_pkg::OFS_IRQ_MASK: st_nxt.rdata = {29'h0, st_r.irq_mask};
                rxb_pkg::OFS_SRC_DIS: st_nxt.rdata = {24'h0, st_r.src_dis};
                default: begin
                    st_nxt.rdata = '0;
                    st_nxt.rresp = RESP_ERR;
                end
            endcase
        end
        if (st_r.rd_pend) begin
            st_nxt.rvalid = 1'b1;
            if (st_r.rd_queue) begin
                st_nxt.rdata = st_r.count != '0 ? q_rdata : '0;
                q_pop = st_r.count != '0;
            end
        end
        st_nxt.rptr = st_r.rptr + QAW'(q_pop);
        st_nxt.count = st_r.count + (QAW+1)'(q_we) - (QAW+1)'(q_pop);
        // Set wins over read clear
        st_nxt.irq_st = st_nxt.irq_st | ev;
        st_nxt.done_irq = st_nxt.count != '0;
        st_nxt.irq = |(st_nxt.irq_st & ~st_nxt.irq_mask);
    end

    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r <= '0;
            st_r.awready <= 1'b1;
            st_r.wready <= 1'b1;
            st_r.arready <= 1'b1;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign rx_dma_active = st_r.dma_en;
    assign frame_normal_evt = st_r.evt_ok;
    assign frame_error_evt = st_r.evt_err;
    assign rx_dma_done_irq = st_r.done_irq;
    assign irq = st_r.irq;
endmodule : rxb_manager

/* File: rtl/rxb_pkg.sv */
// Purpose: Shared constants for the receive DMA buffer manager
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Offsets are byte addresses
package rxb_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [7:0] OFS_R0 = 8'h00;
    localparam logic [7:0] OFS_R4 = 8'h04;
    localparam logic [7:0] OFS_R5 = 8'h08;
    localparam logic [7:0] OFS_R6 = 8'h0c;
    localparam logic [7:0] OFS_R7 = 8'h10;
    localparam logic [7:0] OFS_CALL = 8'h14;
    localparam logic [7:0] OFS_QUEUE = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1c;
    localparam logic [7:0] OFS_IRQ_ST = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFS_SRC_DIS = 8'h28;
    // Call codes written to the call register
    typedef enum logic [2:0] {
        CALL_NONE = 3'b000,
        CALL_RELEASE = 3'b001,
        CALL_SRC_CTRL = 3'b010,
        CALL_ENABLE = 3'b011,
        CALL_DISABLE = 3'b100,
        CALL_ERRSTAT = 3'b101
    } rxb_call_e;
    // Release result codes
    localparam logic [2:0] RES_OK = 3'b000;
    localparam logic [2:0] RES_INVALID = 3'b010;
    localparam logic [2:0] RES_NO_BUF = 3'b011;
    localparam logic [2:0] RES_FREED = 3'b100;
    // Start address layout
    localparam logic [4:0] ADDR_TOP = 5'h01;
    localparam int LIST_W = 7;
    localparam int QUEUE_DEPTH = 32;
    localparam int WORD_W = 12;
    localparam int MAX_WORDS = 4096;
    localparam int SRC_W = 8;
    // Entry fields
    localparam int ENT_VALID = 28;
    localparam int ENT_WORD_LO = 16;
    localparam int ENT_ADDR_LO = 11;
    localparam int ENT_ADDR_HI = 26;
    // Error status bits
    localparam int ERR_FRAME = 0;
    localparam int ERR_SIZE = 2;
    localparam int ERR_DISCARD = 3;
    // Interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_NORMAL = 0;
    localparam int IRQ_ERROR = 1;
    localparam int IRQ_QUEUE = 2;
endpackage : rxb_pkg

/* File: rtl/rxb_queue_mem.sv */
// Purpose: Storage for receive buffer information entries
// Assumes: One write and one read port, registered read data
// Notes: Read data shows the addressed word one cycle later
`timescale 1ns/10ps
module rxb_queue_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic ref_clk,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule : rxb_queue_mem

/* File: verification/rxb_mac_model.sv */
// Purpose: Behavioural receive MAC feeding frame pulses
// Assumes: Driven after rising edges by non-blocking assignment
// Notes: Idle data lines show inverted values, never held ones
`timescale 1ns/10ps
module rxb_mac_model (
    input wire logic ref_clk,
    output logic mac_frame_start,
    output logic mac_frame_end,
    output logic mac_frame_ok,
    output logic [7:0] mac_frame_src,
    output logic [12:0] mac_frame_words
);
    initial begin
        mac_frame_start = 1'b0;
        mac_frame_end = 1'b0;
        mac_frame_ok = 1'b0;
        mac_frame_src = 8'h00;
        mac_frame_words = 13'h0000;
    end
    task automatic begin_frame();
        @(posedge ref_clk);
        mac_frame_start <= 1'b1;
        @(posedge ref_clk);
        mac_frame_start <= 1'b0;
    endtask : begin_frame
    task automatic end_frame(input logic [7:0] s, input logic ok,
        input logic [12:0] w);
        @(posedge ref_clk);
        mac_frame_end <= 1'b1;
        mac_frame_ok <= ok;
        mac_frame_src <= s;
        mac_frame_words <= w;
        @(posedge ref_clk);
        mac_frame_end <= 1'b0;
        mac_frame_ok <= ~ok;
        mac_frame_src <= ~s;
        mac_frame_words <= ~w;
        @(posedge ref_clk);
    endtask : end_frame
endmodule : rxb_mac_model

/* File: verification/rxb_manager_props.sv */
// Purpose: Port-level checks for the receive buffer manager
// Assumes: One clock, reset_n active low
// Notes: Bound to the manager from the bench top file
`timescale 1ns/10ps
module rxb_manager_props (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mac_frame_start,
    input wire logic mac_frame_end,
    input wire logic mac_frame_ok,
    input wire logic rx_dma_active,
    input wire logic frame_normal_evt,
    input wire logic frame_error_evt,
    input wire logic rx_dma_done_irq
);
    logic in_frame_r;
    logic [3:0] wr_age_r;
    logic [3:0] rd_age_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Frame in flight, and cycles since the last bus request
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            in_frame_r <= 1'b0;
            wr_age_r <= 4'hf;
            rd_age_r <= 4'hf;
        end else begin
            in_frame_r <= rx_dma_active && !mac_frame_end &&
                (in_frame_r || mac_frame_start);
            wr_age_r <= (s_axi_awvalid && s_axi_awready) ? 4'h0 :
                wr_age_r + {3'h0, wr_age_r != 4'hf};
            rd_age_r <= (s_axi_arvalid && s_axi_arready) ? 4'h0 :
                rd_age_r + {3'h0, rd_age_r != 4'hf};
        end
    end
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready
        |-> ##2 s_axi_rvalid) else $error("read response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    normal_cause_a: assert property (frame_normal_evt
        |-> $past(mac_frame_end) && $past(mac_frame_ok))
        else $error("normal event without good frame end");
    error_follow_a: assert property (mac_frame_end && in_frame_r
        && !mac_frame_ok |=> frame_error_evt)
        else $error("bad frame gave no error event");
    event_excl_a: assert property (!(frame_normal_evt && frame_error_evt))
        else $error("both frame events high");
    event_pulse_a: assert property (frame_normal_evt |=> !frame_normal_evt)
        else $error("normal event longer than one cycle");
    done_rise_a: assert property ($rose(rx_dma_done_irq) |->
        $past(mac_frame_end) || $past(mac_frame_end, 2) ||
        $past(mac_frame_end, 3)) else $error("done irq rose without frame");
    done_fall_a: assert property ($fell(rx_dma_done_irq)
        |-> rd_age_r < 4'h8) else $error("done irq fell without a read");
    dma_on_a: assert property ($rose(rx_dma_active) |-> wr_age_r < 4'h8)
        else $error("receive DMA enabled without a call");
endmodule : rxb_manager_props

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the receive buffer manager
// Assumes: AXI4-Lite master tasks, behavioural MAC model
// Notes: A set mask bit hides the matching status bit
`timescale 1ns/10ps
module tb;
    logic ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d, ba;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, rx_dma_active, frame_normal_evt, frame_error_evt;
    logic rx_dma_done_irq, irq, mac_frame_start, mac_frame_end, mac_frame_ok;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
    logic [7:0] mac_frame_src;
    logic [12:0] mac_frame_words;
    int fails = 0, cmp_count = 0, cyc = 0;
    rxb_manager rxb_manager_inst (.ref_clk, .reset_n, .clk_en, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .mac_frame_start, .mac_frame_end, .mac_frame_ok, .mac_frame_src,
        .mac_frame_words, .rx_dma_active, .frame_normal_evt,
        .frame_error_evt, .rx_dma_done_irq, .irq);
    rxb_mac_model rxb_mac_model_inst (.ref_clk, .mac_frame_start,
        .mac_frame_end, .mac_frame_ok, .mac_frame_src, .mac_frame_words);
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            final_report();
        end
    end
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tend(input string n);
        $display("test %s done, mismatches %0d", n, fails);
    endtask : tend
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rd_d, exp);
    endtask : rdc
    task automatic call(input logic [2:0] c, input logic [31:0] r4,
        input logic [31:0] r5, input logic [31:0] r6);
        wr(rxb_pkg::OFS_R4, r4);
        wr(rxb_pkg::OFS_R5, r5);
        wr(rxb_pkg::OFS_R6, r6);
        wr(rxb_pkg::OFS_R7, 32'h0);
        wr(rxb_pkg::OFS_CALL, {29'h0, c});
        rd(rxb_pkg::OFS_R0);
    endtask : call
    task automatic frame(input logic [7:0] s, input logic ok,
        input logic [12:0] w);
        rxb_mac_model_inst.begin_frame();
        rxb_mac_model_inst.end_frame(s, ok, w);
    endtask : frame
    initial begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({30'h0, irq, rx_dma_done_irq}, 32'h0); // idle
        rdc(rxb_pkg::OFS_STAT, 32'h0);
        rdc(rxb_pkg::OFS_QUEUE, 32'h0); // empty
        rd(8'hfc);
        chk({30'h0, rd_resp}, 32'h2);
        tend("reset");
        call(3'h6, 32'h0, 32'h0, 32'h0);
        chk(rd_d & 32'h7, 32'h2); // bad code
        call(rxb_pkg::CALL_RELEASE, 32'h0c00_0000, 32'h0c00_0000, 32'h1);
        chk(rd_d & 32'h7, 32'h2); // bad argument
        call(rxb_pkg::CALL_RELEASE, 32'h0, 32'h0, 32'h0);
        chk(rd_d & 32'h7, 32'h3); // no buffer
        tend("arguments");
        call(rxb_pkg::CALL_ENABLE, 32'h0, 32'h0, 32'h0);
        chk({31'h0, rx_dma_active}, 32'h1); // enabled
        wr(rxb_pkg::OFS_IRQ_MASK, 32'h0);
        frame(8'h00, 1'b1, 13'd20);
        rdc(rxb_pkg::OFS_STAT, 32'h3); // one entry
        chk({30'h0, irq, rx_dma_done_irq}, 32'h3); // raised
        rdc(rxb_pkg::OFS_IRQ_ST, 32'h5); // normal event
        rdc(rxb_pkg::OFS_IRQ_ST, 32'h0);
        rdc(rxb_pkg::OFS_QUEUE, 32'h1014_8000); // entry
        ba = {5'b00001, rd_d[15:0], 11'h000};
        chk(ba, 32'h0c00_0000); // start address
        rdc(rxb_pkg::OFS_STAT, 32'h1);
        chk({31'h0, rx_dma_done_irq}, 32'h0); // drained
        call(rxb_pkg::CALL_RELEASE, ba, ba, 32'h0);
        chk(rd_d & 32'h6, 32'h0); // success
        call(rxb_pkg::CALL_RELEASE, ba, ba, 32'h0);
        chk(rd_d & 32'h7, 32'h4); // released twice
        tend("single");
        for (int i = 1; i <= 33; i++) frame(8'h00, 1'b1, 13'(i));
        wr(rxb_pkg::OFS_IRQ_MASK, 32'h7);
        rdc(rxb_pkg::OFS_STAT, 32'h41); // full at 32
        chk({31'h0, irq}, 32'h0);
        rdc(rxb_pkg::OFS_IRQ_ST, 32'h5);
        wr(rxb_pkg::OFS_IRQ_MASK, 32'h0);
        for (int i = 1; i <= 32; i++) begin
            rdc(rxb_pkg::OFS_QUEUE, {4'h1, 12'(i), 1'b1, 7'(i), 8'h00});
        end
        rdc(rxb_pkg::OFS_QUEUE, 32'h0); // empty again
        chk({31'h0, rx_dma_done_irq}, 32'h0); // drained
        tend("fill");
        call(rxb_pkg::CALL_SRC_CTRL, 32'h04, 32'h0, 32'h0); // source 2
        frame(8'h02, 1'b1, 13'd8);
        rdc(rxb_pkg::OFS_STAT, 32'h1); // discarded
        rd(rxb_pkg::OFS_IRQ_ST);
        frame(8'h01, 1'b0, 13'd8);
        rdc(rxb_pkg::OFS_IRQ_ST, 32'h2); // error event
        frame(8'h00, 1'b1, 13'd4097);
        call(rxb_pkg::CALL_ERRSTAT, 32'h0, 32'h0, 32'h0);
        chk(rd_d & 32'hf, 32'hd); // status bits
        call(rxb_pkg::CALL_ERRSTAT, 32'h0, 32'h0, 32'h0);
        chk(rd_d & 32'hf, 32'h0); // cleared
        rd(rxb_pkg::OFS_QUEUE);
        tend("sources");
        rxb_mac_model_inst.begin_frame();
        call(rxb_pkg::CALL_DISABLE, 32'h0, 32'h0, 32'h0);
        chk({31'h0, rx_dma_active}, 32'h1); // kept on
        call(rxb_pkg::CALL_DISABLE, 32'h1, 32'h0, 32'h0);
        chk({31'h0, rx_dma_active}, 32'h0); // forced off
        rxb_mac_model_inst.end_frame(8'h00, 1'b1, 13'd8);
        call(rxb_pkg::CALL_DISABLE, 32'h1, 32'h0, 32'h0);
        rdc(rxb_pkg::OFS_STAT, 32'h0); // stays off
        tend("disable");
        final_report();
    end
endmodule : tb
bind rxb_manager rxb_manager_props rxb_manager_props_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .mac_frame_start(mac_frame_start), .mac_frame_end(mac_frame_end),
    .mac_frame_ok(mac_frame_ok), .rx_dma_active(rx_dma_active),
    .frame_normal_evt(frame_normal_evt), .frame_error_evt(frame_error_evt),
    .rx_dma_done_irq(rx_dma_done_irq));
